/* hw/msp_cfg.svh */
`ifndef MSP_CFG_SVH
`define MSP_CFG_SVH

// Register offsets (byte addresses, one 32-bit word each).
`define MSP_OFS_PIN_LEVEL      8'h00
`define MSP_OFS_OUTPUT_LATCH   8'h04
`define MSP_OFS_DIRECTION      8'h08
`define MSP_OFS_ANALOG_LOW     8'h0C
`define MSP_OFS_ANALOG_HIGH    8'h10
`define MSP_OFS_OVERRIDE_CTL   8'h14

// Reset values.
`define MSP_RST_LATCH          8'h00
`define MSP_RST_DIRECTION      8'hFE
`define MSP_RST_ANALOG_LOW     8'hFF
`define MSP_RST_ANALOG_HIGH    8'hFF
`define MSP_RST_OVERRIDE       8'h00

// Implemented port bits: 7 down to 1.
`define MSP_PORT_MASK          8'hFE

// Analog channel carried by each pin: pin 1 ch6, 2 ch7, 3 ch8, 4 ch9,
// 5 ch10, 6 ch11, 7 ch5.
`define MSP_CH_PIN1            6
`define MSP_CH_PIN2            7
`define MSP_CH_PIN3            8
`define MSP_CH_PIN4            9
`define MSP_CH_PIN5            10
`define MSP_CH_PIN6            11
`define MSP_CH_PIN7            5

// Override control register fields.
`define MSP_OVR_CMP2_PIN1      0
`define MSP_OVR_CMP1_PIN2      1
`define MSP_OVR_VREF_PIN5      2

`endif

/* hw/msp_pad_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface msp_pad_if;
    import msp_pkg::*;
    msp_byte_t drive_val;
    msp_byte_t drive_en;
    msp_byte_t dig_in_en;
    msp_byte_t pin_sync;
    modport ctrl (output drive_val, output drive_en, output dig_in_en,
                  input pin_sync);
    modport pad  (input drive_val, input drive_en, input dig_in_en,
                  output pin_sync);
endinterface
`default_nettype wire

/* hw/msp_pad_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module msp_pad_sync
    import msp_pkg::*;
(
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    // Raw pins
    input  wire logic [7:0] i_pin,
    // Synchronised pins
    msp_pad_if.pad          pad
);
    msp_byte_t meta_r;
    msp_byte_t sync_r;

    // Pins are asynchronous; the first stage feeds only the second.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= 8'h00;
            sync_r <= 8'h00;
        end else begin
            meta_r <= i_pin;
            sync_r <= meta_r;
        end
    end

    assign pad.pin_sync = sync_r;
endmodule
`default_nettype wire

/* hw/msp_pkg.sv */
package msp_pkg;
    typedef logic [7:0]  msp_byte_t;
    typedef logic [15:0] msp_chan_t;
    typedef enum logic [1:0] {
        MSP_BUS_IDLE = 2'b00,
        MSP_BUS_ACK  = 2'b01
    } msp_bus_state_t;
endpackage

/* hw/msp_port.sv */
// The implementer's own choices: the address map and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "msp_cfg.svh"
// How it works
// RL1: Output direction drives latch, analog ignored.
// RL2: Input direction releases driver, reads pin.
// RL3: Analog selection disables pin digital input (only for pin reads; the pin 7 and pin 1 taps still follow the pin).
// RL4: Reset selects analog on every channel.
// RL5: Enabled comparator results replace latch on output.
// RL6: Reference output kills pin 5 digital I/O.
// RL7: Pin 7 input feeds serial slave select.
// RL8: Pin 1 input feeds pulse delay input.
// RL9: Bit 0 unimplemented, always reads zero.
// RL10: Each analog-select bit controls one channel.
// RL11: Analog-configured pins read back as zero.
// RL12: Software must also turn comparators off.
// RL13: Pin writes load latch; latch reads latch.
module msp_port
    import msp_pkg::*;
(
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    // Wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    output logic             o_wb_err,
    // Port pins
    input  wire logic [7:0]  i_pin,
    output logic [7:0]       o_pin,
    output logic [7:0]       o_pin_oe,
    // Comparator results
    input  wire logic        i_comparator_one_result,
    input  wire logic        i_comparator_two_result,
    // Peripheral inputs routed from the port
    output logic             o_serial_slave_select_in,
    output logic             o_pulse_delay_in,
    // Analog side
    output logic [15:0]      o_analog_select,
    output logic             o_comparator_reference_out
);
    msp_pad_if pad_bus ();

    msp_pad_sync u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_pin     (i_pin),
        .pad       (pad_bus)
    );

    msp_byte_t      latch_r;
    msp_byte_t      dir_r;
    msp_byte_t      an_low_r;
    msp_byte_t      an_high_r;
    msp_byte_t      ovr_r;
    msp_bus_state_t bus_r;
    msp_chan_t      an_sel;
    msp_byte_t      pin_an;
    msp_byte_t      drv_val;
    msp_byte_t      drv_en;
    msp_byte_t      din_en;
    msp_byte_t      pin_read;
    msp_byte_t      wr_byte;
    logic [31:0]    rd_nxt;
    logic           req;
    logic           take;
    logic           hit;

    // Gathers the analog-select bit that belongs to each pin.
    function automatic msp_byte_t pin_analog(input msp_chan_t sel);
        msp_byte_t p;
        p    = 8'h00;
        p[1] = sel[`MSP_CH_PIN1];
        p[2] = sel[`MSP_CH_PIN2];
        p[3] = sel[`MSP_CH_PIN3];
        p[4] = sel[`MSP_CH_PIN4];
        p[5] = sel[`MSP_CH_PIN5];
        p[6] = sel[`MSP_CH_PIN6];
        p[7] = sel[`MSP_CH_PIN7];
        return p;
    endfunction

    // Returns 1 when the address maps to a register.
    function automatic logic addr_hit(input logic [7:0] a);
        if (a == `MSP_OFS_PIN_LEVEL) begin
            return 1'b1;
        end else if (a == `MSP_OFS_OUTPUT_LATCH) begin
            return 1'b1;
        end else if (a == `MSP_OFS_DIRECTION) begin
            return 1'b1;
        end else if (a == `MSP_OFS_ANALOG_LOW) begin
            return 1'b1;
        end else if (a == `MSP_OFS_ANALOG_HIGH) begin
            return 1'b1;
        end else if (a == `MSP_OFS_OVERRIDE_CTL) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    // One analog-select bit per channel.
    assign an_sel  = {an_high_r, an_low_r}; // RL10
    assign pin_an  = pin_analog(an_sel);
    assign wr_byte = i_wb_dat[7:0];

    // Only byte lane 0 carries data; the upper lanes read as zero.
    assign req  = i_wb_cyc && i_wb_stb && (bus_r == MSP_BUS_IDLE);
    assign hit  = addr_hit(i_wb_adr);
    assign take = req && hit && i_wb_sel[0];

    // Pin drivers and input enables.
    always_comb begin
        drv_val = latch_r; // RL1
        drv_en  = ~dir_r & `MSP_PORT_MASK; // RL1 RL2
        din_en  = dir_r & ~pin_an & `MSP_PORT_MASK; // RL2 RL3
        // Comparator results take priority over the latch when driving.
        if (ovr_r[`MSP_OVR_CMP2_PIN1]) begin
            drv_val[1] = i_comparator_two_result; // RL5
        end
        if (ovr_r[`MSP_OVR_CMP1_PIN2]) begin
            drv_val[2] = i_comparator_one_result; // RL5
        end
        // The reference output owns pin 5 whatever its direction is.
        if (ovr_r[`MSP_OVR_VREF_PIN5]) begin
            drv_en[5] = 1'b0; // RL6
            din_en[5] = 1'b0; // RL6
        end
    end

    assign pad_bus.drive_val = drv_val;
    assign pad_bus.drive_en  = drv_en;
    assign pad_bus.dig_in_en = din_en;

    // A disabled input path reads zero, as does bit 0.
    assign pin_read = pad_bus.pin_sync & pad_bus.dig_in_en; // RL2 RL9 RL11

    // Output latch; a write to either port register loads it.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            latch_r <= `MSP_RST_LATCH;
        end else if (take && i_wb_we &&
                     (i_wb_adr == `MSP_OFS_PIN_LEVEL ||
                      i_wb_adr == `MSP_OFS_OUTPUT_LATCH)) begin
            latch_r <= wr_byte & `MSP_PORT_MASK; // RL13 RL9
        end
    end

    // Direction register; bit 0 does not exist.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dir_r <= `MSP_RST_DIRECTION;
        end else if (take && i_wb_we &&
                     i_wb_adr == `MSP_OFS_DIRECTION) begin
            dir_r <= wr_byte & `MSP_PORT_MASK; // RL9
        end
    end

    // Analog select comes up all analog after reset.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            an_low_r  <= `MSP_RST_ANALOG_LOW; // RL4
            an_high_r <= `MSP_RST_ANALOG_HIGH; // RL4
        end else if (take && i_wb_we) begin
            if (i_wb_adr == `MSP_OFS_ANALOG_LOW) begin
                an_low_r <= wr_byte; // RL10
            end else if (i_wb_adr == `MSP_OFS_ANALOG_HIGH) begin
                an_high_r <= wr_byte; // RL10
            end
        end
    end

    // Comparator output and reference output enables. Clearing these is
    // how software turns the comparators off the pins.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ovr_r <= `MSP_RST_OVERRIDE;
        end else if (take && i_wb_we &&
                     i_wb_adr == `MSP_OFS_OVERRIDE_CTL) begin
            ovr_r <= wr_byte & 8'h07; // RL12
        end
    end

    // Read data mux.
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (i_wb_adr == `MSP_OFS_PIN_LEVEL) begin
            rd_nxt[7:0] = pin_read; // RL2
        end else if (i_wb_adr == `MSP_OFS_OUTPUT_LATCH) begin
            rd_nxt[7:0] = latch_r; // RL13
        end else if (i_wb_adr == `MSP_OFS_DIRECTION) begin
            rd_nxt[7:0] = dir_r; // RL9
        end else if (i_wb_adr == `MSP_OFS_ANALOG_LOW) begin
            rd_nxt[7:0] = an_low_r;
        end else if (i_wb_adr == `MSP_OFS_ANALOG_HIGH) begin
            rd_nxt[7:0] = an_high_r;
        end else if (i_wb_adr == `MSP_OFS_OVERRIDE_CTL) begin
            rd_nxt[7:0] = ovr_r;
        end
    end

    // Single-cycle Wishbone answer; ack or err one cycle after the
    // request, then one idle cycle so a held strobe is not taken twice.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus_r    <= MSP_BUS_IDLE;
            o_wb_ack <= 1'b0;
            o_wb_err <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= 1'b0;
            o_wb_err <= 1'b0;
            case (bus_r)
                MSP_BUS_IDLE: begin
                    if (req) begin
                        bus_r <= MSP_BUS_ACK;
                        if (hit) begin
                            o_wb_ack <= 1'b1;
                            o_wb_dat <= i_wb_we ? 32'h0000_0000 : rd_nxt;
                        end else begin
                            o_wb_err <= 1'b1;
                            o_wb_dat <= 32'h0000_0000;
                        end
                    end
                end
                default: begin
                    bus_r <= MSP_BUS_IDLE;
                end
            endcase
        end
    end

    // Registered pin outputs.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pin    <= 8'h00;
            o_pin_oe <= 8'h00;
        end else begin
            o_pin    <= pad_bus.drive_val & pad_bus.drive_en;
            o_pin_oe <= pad_bus.drive_en; // RL1 RL2 RL6
        end
    end

    // Peripheral taps: only while the pin is an input. Pin 7 slave select
    // is active low, so it idles high when not routed.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_serial_slave_select_in <= 1'b1;
            o_pulse_delay_in         <= 1'b0;
        end else begin
            o_serial_slave_select_in <= dir_r[7] ?
                                        pad_bus.pin_sync[7] : 1'b1; // RL7
            o_pulse_delay_in         <= dir_r[1] &
                                        pad_bus.pin_sync[1]; // RL8
        end
    end

    // Analog controls to the converter and reference.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_analog_select            <= 16'hFFFF; // RL4
            o_comparator_reference_out <= 1'b0;
        end else begin
            o_analog_select            <= an_sel;
            o_comparator_reference_out <= ovr_r[`MSP_OVR_VREF_PIN5]; // RL6
        end
    end
endmodule
`default_nettype wire

/* sim/msp_port_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module msp_port_sva (
    // Clock, reset and bus
    input wire logic        i_ref_clk,
    input wire logic        i_rst_n,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        o_wb_ack,
    input wire logic        o_wb_err,
    // Pins and routed signals
    input wire logic [7:0]  o_pin,
    input wire logic [7:0]  o_pin_oe,
    input wire logic        o_serial_slave_select_in,
    input wire logic        o_pulse_delay_in,
    input wire logic [15:0] o_analog_select,
    input wire logic        o_comparator_reference_out
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    a_bus_answer: assert property (
        $rose(i_wb_cyc & i_wb_stb) |=> (o_wb_ack ^ o_wb_err))
        else $error("request without a single answer");
    a_answer_cause: assert property (
        (o_wb_ack | o_wb_err) |-> $past(i_wb_cyc & i_wb_stb))
        else $error("answer without a request");
    a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    a_bit0_zero: assert property (
        o_pin[0] == 1'b0 && o_pin_oe[0] == 1'b0)
        else $error("bit 0 driven");
    a_undriven_low: assert property ((o_pin & ~o_pin_oe) == 8'h00)
        else $error("value on a released pin");
    a_ref_pin5: assert property (
        o_comparator_reference_out && $past(o_comparator_reference_out)
        |-> !o_pin_oe[5])
        else $error("pin 5 driven with reference out");
    a_ssel_idle: assert property (
        o_pin_oe[7] && $past(o_pin_oe[7]) |-> o_serial_slave_select_in)
        else $error("slave select follows an output pin");
    a_pdelay_idle: assert property (
        o_pin_oe[1] && $past(o_pin_oe[1]) |-> !o_pulse_delay_in)
        else $error("pulse delay follows an output pin");
    a_reset_analog: assert property ($rose(i_rst_n) |->
        o_analog_select == 16'hFFFF && o_pin_oe == 8'h00)
        else $error("reset state not analog input");
endmodule
bind msp_port msp_port_sva u_sva (
    .i_ref_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .o_wb_err,
    .o_pin, .o_pin_oe, .o_serial_slave_select_in, .o_pulse_delay_in,
    .o_analog_select, .o_comparator_reference_out);
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "msp_cfg.svh"
module tb_top;
    import msp_pkg::*;
    typedef struct packed {
        logic [7:0] dir, ovr, al, ah, pin, oe, out, rdv;
        logic [1:0] sp;
    } msp_row_t;
    logic        i_ref_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        i_wb_cyc = 1'b0;
    logic        i_wb_stb = 1'b0;
    logic        i_wb_we = 1'b0;
    logic [7:0]  i_wb_adr = 8'h00;
    logic [3:0]  i_wb_sel = 4'h0;
    logic [31:0] i_wb_dat = 32'h0000_0000;
    logic [7:0]  i_pin = 8'hFF;
    logic        i_comparator_one_result = 1'b1;
    logic        i_comparator_two_result = 1'b0;
    logic [31:0] o_wb_dat;
    logic        o_wb_ack;
    logic        o_wb_err;
    logic [7:0]  o_pin;
    logic [7:0]  o_pin_oe;
    logic        o_serial_slave_select_in;
    logic        o_pulse_delay_in;
    logic [15:0] o_analog_select;
    logic        o_comparator_reference_out;
    wire  [1:0]  sp = {o_serial_slave_select_in, o_pulse_delay_in};
    int          n_fail = 0;
    int          comparisons = 0;
    int          ticks = 0;
    logic [31:0] rd;
    logic        er;
    msp_row_t    r;
    localparam logic [7:0] RADR [6] = '{`MSP_OFS_PIN_LEVEL,
        `MSP_OFS_OUTPUT_LATCH, `MSP_OFS_DIRECTION, `MSP_OFS_ANALOG_LOW,
        `MSP_OFS_ANALOG_HIGH, `MSP_OFS_OVERRIDE_CTL};
    localparam logic [7:0] RVAL [6] = '{8'h00, 8'h00, 8'hFE, 8'hFF,
        8'hFF, 8'h00};
    // Latch holds 7A and comparator one/two give 1/0, so that an
    // override shows as a flipped bit on pins 1 and 2.
    localparam msp_row_t ROWS [8] = '{
        {8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFE, 8'h7A, 8'h00, 2'h2},
        {8'hFE, 8'h00, 8'h00, 8'h00, 8'h25, 8'h00, 8'h00, 8'h24, 2'h0},
        {8'hFE, 8'h00, 8'h00, 8'h00, 8'hDA, 8'h00, 8'h00, 8'hDA, 2'h3},
        {8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'hFE, 8'h7C, 8'h00, 2'h2},
        {8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'hDE, 8'h5A, 8'h00, 2'h2},
        {8'hFE, 8'h04, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hDE, 2'h3},
        {8'hFE, 8'h00, 8'h80, 8'h04, 8'hFF, 8'h00, 8'h00, 8'hDA, 2'h3},
        {8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFE, 8'h7A, 8'h00, 2'h2}};

    msp_port uut (
        .i_ref_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
        .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_wb_err, .i_pin,
        .o_pin, .o_pin_oe, .i_comparator_one_result,
        .i_comparator_two_result, .o_serial_slave_select_in,
        .o_pulse_delay_in, .o_analog_select, .o_comparator_reference_out);

    always #4 i_ref_clk = ~i_ref_clk;

    task automatic summarize;
        if (n_fail == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge i_ref_clk) begin
        ticks++;
        if (ticks == 3000) begin
            n_fail++;
            summarize;
        end
    end

    task automatic chk(input string nm, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge i_ref_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we  <= w;
        i_wb_adr <= a;
        i_wb_sel <= s;
        i_wb_dat <= d;
        do @(posedge i_ref_clk);
        while (o_wb_ack !== 1'b1 && o_wb_err !== 1'b1);
        rd = o_wb_dat;
        er = o_wb_err;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] x);
        bus(1'b0, a, 32'h0000_0000, 4'hF);
        chk("reg", rd, {24'h00_0000, x});
    endtask

    initial begin
        repeat (8) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        foreach (RADR[k]) rdc(RADR[k], RVAL[k]);
        wr(`MSP_OFS_PIN_LEVEL, 32'hFFFF_FF7B);
        rdc(`MSP_OFS_OUTPUT_LATCH, 8'h7A);
        foreach (ROWS[k]) begin
            r = ROWS[k];
            i_pin <= r.pin;
            wr(`MSP_OFS_DIRECTION, {24'h00_0000, r.dir});
            wr(`MSP_OFS_OVERRIDE_CTL, {24'h00_0000, r.ovr});
            wr(`MSP_OFS_ANALOG_LOW, {24'h00_0000, r.al});
            wr(`MSP_OFS_ANALOG_HIGH, {24'h00_0000, r.ah});
            repeat (3) @(posedge i_ref_clk);
            bus(1'b0, `MSP_OFS_PIN_LEVEL, 32'h0000_0000, 4'hF);
            chk("oe", o_pin_oe, r.oe);
            chk("out", o_pin, r.out);
            chk("pin_rd", rd, r.rdv);
            chk("routed", sp, r.sp);
            chk("ana", o_analog_select, {r.ah, r.al});
            chk("ref", o_comparator_reference_out, r.ovr[2]);
        end
        // Both comparators low: pins 1 and 2 must follow them, not the latch
        // and not its inverse, so a copied or inverted latch bit shows here.
        i_comparator_one_result <= 1'b0;
        i_comparator_two_result <= 1'b0;
        wr(`MSP_OFS_DIRECTION, 32'h0000_0000);
        wr(`MSP_OFS_OVERRIDE_CTL, 32'h0000_0003);
        repeat (2) @(posedge i_ref_clk);
        chk("out_cmp", o_pin, 8'h78);
        // A write with sel[0] low is acknowledged but must leave the latch.
        bus(1'b1, `MSP_OFS_OUTPUT_LATCH, 32'h0000_0000, 4'h0);
        rdc(`MSP_OFS_OUTPUT_LATCH, 8'h7A);
        bus(1'b0, 8'h40, 32'h0000_0000, 4'hF);
        chk("err", er, 1'b1);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        chk("oe_rst", o_pin_oe, 8'h00);
        i_rst_n <= 1'b1;
        foreach (RADR[k]) rdc(RADR[k], RVAL[k]);
        summarize;
    end
endmodule
`default_nettype wire
